// [dv/fpk_host_model.sv]
// host processor model at the far end of the serial link
`timescale 1ns/100ps
`default_nettype none

module fpk_host_model #(
  parameter int BAUD_DIV = 16
) (
  input  wire logic clk,
  input  wire logic link_in,
  output var  logic link_out
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial link_out = 1'b1;

  // ==========================================================
  // byte frame out
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      #1 link_out = fr[i];
      repeat (BAUD_DIV - 1) @(posedge clk);
    end
    // a broken frame is followed by idle so the next start edge is seen
    @(posedge clk);
    #1 link_out = 1'b1;
    if (!stop) repeat (BAUD_DIV) @(posedge clk);
  endtask

  // ==========================================================
  // byte frame in
  always
  begin
    @(negedge link_in);
    repeat (BAUD_DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BAUD_DIV) @(posedge clk);
      sh[i] = link_in;
    end
    repeat (BAUD_DIV) @(posedge clk);
    rx_q.push_back(sh);
  end
endmodule // fpk_host_model

`default_nettype wire

// [dv/fpk_panel_assertions.sv]
// port checker for the panel controller
`timescale 1ns/100ps
`default_nettype none

module fpk_panel_chk #(
  parameter int SCAN_DIV  = 8,
  parameter int BELL_HALF = 4
) (
  // clock and reset
  input wire logic       CLK_SYS,
  input wire logic       SYS_RST,
  // watched ports
  input wire logic       HOST_TXD,
  input wire logic [3:0] KA_COL_N,
  input wire logic [2:0] KB_COL_N,
  input wire logic       RST_BTN_N,
  input wire logic       LCD_WR,
  input wire logic       LCD_RST,
  input wire logic [5:0] LCD_COL,
  input wire logic [7:0] LCD_DATA,
  input wire logic       BUZZER,
  input wire logic       TERM_SENSE,
  input wire logic       TERM_PORT_EN,
  input wire logic       TERM_SENSE_HOST,
  input wire logic       LED_CTL,
  input wire logic       LED_OUT
);
  // ==========================================================
  // run lengths, repetition counts stay small this way
  int hi_cnt;
  int lo_cnt;
  int up_cnt;
  always @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      hi_cnt <= 0;
      lo_cnt <= 0;
      up_cnt <= 0;
    end
    else
    begin
      hi_cnt <= BUZZER ? hi_cnt + 1 : 0;
      lo_cnt <= RST_BTN_N ? 0 : lo_cnt + 1;
      up_cnt <= RST_BTN_N ? up_cnt + 1 : 0;
    end

  // ==========================================================
  // properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence start_bit;
    !HOST_TXD [*8];
  endsequence
  sequence wr_once;
    LCD_WR ##1 !LCD_WR;
  endsequence
  a_led_follow: assert property (
    !$past(SYS_RST) |-> LED_OUT == $past(LED_CTL)) else $error("lamp not following host");
  a_term_blocked: assert property (
    !$past(SYS_RST) && $past(TERM_SENSE) |-> !TERM_PORT_EN && TERM_SENSE_HOST)
    else $error("terminal port not blocked");
  a_wr_pulse: assert property (LCD_WR |-> wr_once) else $error("write strobe too long");
  a_wr_char: assert property (
    LCD_WR |-> LCD_DATA >= 8'h20 && LCD_DATA <= 8'h7E && LCD_COL <= 6'h27)
    else $error("bad display write");
  a_col_step: assert property (
    LCD_WR && LCD_COL < 6'h27 |=> LCD_COL == $past(LCD_COL) + 6'h01) else $error("no col step");
  a_col_wrap: assert property (
    LCD_WR && LCD_COL == 6'h27 |=> LCD_COL == 6'h00) else $error("column did not wrap");
  a_tx_start: assert property ($fell(HOST_TXD) |-> start_bit) else $error("short start");
  a_bell_half: assert property (hi_cnt <= BELL_HALF) else $error("buzzer half too long");
  a_scan_big: assert property ($onehot(~KA_COL_N)) else $error("bad 4x4 column");
  a_scan_small: assert property ($onehot0(~KB_COL_N)) else $error("bad 3x4 column");
  a_btn_release: assert property (
    up_cnt > 5 * SCAN_DIV |-> !LCD_RST) else $error("display reset stuck");
  a_btn_debounce: assert property (
    $rose(LCD_RST) |-> lo_cnt >= SCAN_DIV) else $error("button not debounced");
endmodule // fpk_panel_chk

bind fpk_panel fpk_panel_chk #(.SCAN_DIV(SCAN_DIV), .BELL_HALF(BELL_HALF)) u_chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HOST_TXD(HOST_TXD), .KA_COL_N(KA_COL_N),
  .KB_COL_N(KB_COL_N), .RST_BTN_N(RST_BTN_N), .LCD_WR(LCD_WR), .LCD_RST(LCD_RST),
  .LCD_COL(LCD_COL), .LCD_DATA(LCD_DATA), .BUZZER(BUZZER), .TERM_SENSE(TERM_SENSE),
  .TERM_PORT_EN(TERM_PORT_EN), .TERM_SENSE_HOST(TERM_SENSE_HOST), .LED_CTL(LED_CTL),
  .LED_OUT(LED_OUT));

`default_nettype wire

// [dv/test_front_panel_keypad_bell_controller.sv]
// self-checking bench for the panel controller
`timescale 1ns/100ps
`default_nettype none

module test_front_panel_keypad_bell_controller;
  localparam int BD = 16;
  localparam int HALF = 4;
  localparam int LEN = 64;
  logic        clk_sys, sys_rst, led_ctl, term_sense, aux_n, btn_n, ka_on, kb_on;
  logic        host_rxd, host_txd, lcd_wr, lcd_clr, lcd_rst, lcd_bklt, buzzer;
  logic        term_port_en, term_sense_host, led_out;
  logic [3:0]  ka_row_n, ka_col_n, kb_row_n;
  logic [2:0]  kb_col_n, lcd_row;
  logic [5:0]  lcd_col;
  logic [7:0]  lcd_data, lfsr, b;
  logic [1:0]  kc, kr;
  logic [16:0] wq[$];
  logic [7:0]  exp4[4] = '{8'h80, 8'hA0, 8'hA1, 8'hB0};
  int          row, col, clrs, rises, r0, errors, checks_done;

  fpk_panel #(.BAUD_DIV(BD), .SCAN_DIV(8), .BELL_HALF(HALF), .BELL_LEN(LEN), .DEB_TICKS(2)) dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .HOST_RXD(host_rxd), .HOST_TXD(host_txd),
    .KA_ROW_N(ka_row_n), .KA_COL_N(ka_col_n), .KB_ROW_N(kb_row_n), .KB_COL_N(kb_col_n),
    .CLK_HOLD_SW_N(aux_n), .RST_BTN_N(btn_n), .LCD_WR(lcd_wr), .LCD_CLR(lcd_clr),
    .LCD_RST(lcd_rst), .LCD_ROW(lcd_row), .LCD_COL(lcd_col), .LCD_DATA(lcd_data),
    .LCD_BKLT(lcd_bklt), .BUZZER(buzzer), .TERM_SENSE(term_sense),
    .TERM_PORT_EN(term_port_en), .TERM_SENSE_HOST(term_sense_host), .LED_CTL(led_ctl),
    .LED_OUT(led_out));
  fpk_host_model #(.BAUD_DIV(BD)) host (.clk(clk_sys), .link_in(host_txd), .link_out(host_rxd));

  // keypads: pressed key pulls its row low while its column is driven
  assign ka_row_n = (ka_on && ka_col_n[kc] === 1'b0) ? ~(4'h1 << kr) : 4'hF;
  assign kb_row_n = (kb_on && kb_col_n[kc] === 1'b0) ? ~(4'h1 << kr) : 4'hF;
  always #2 clk_sys = ~clk_sys;

  // ==========================================================
  // compare and finish
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (host.rx_q.size() < n && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    #1;
    if (host.rx_q.size() < n)
    begin
      errors++;
      stop_test();
    end
  endtask

  // ==========================================================
  // display model: cursor and expected writes
  task automatic host_byte(input logic [7:0] c, input logic ok);
    if (ok && c >= 8'h20 && c <= 8'h7E)
    begin
      wq.push_back({row[2:0], col[5:0], c});
      col = (col + 1) % 40;
      if (col == 0)
        row = (row + 1) % 8;
    end
    else if (ok && c == 8'h0A)
      row = (row + 1) % 8;
    else if (ok && (c == 8'h0D || c == 8'h0C))
      col = 0;
    if (ok && c == 8'h0C)
      row = 0;
    host.send_byte(c, ok);
    @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys)
  begin
    if (lcd_wr === 1'b1 && wq.size() == 0)
      check(32'h1, 32'h0);
    else if (lcd_wr === 1'b1)
      check({lcd_row, lcd_col, lcd_data}, wq.pop_front());
    if (lcd_clr === 1'b1)
      clrs++;
  end
  always @(posedge buzzer)
    rises++;
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {clk_sys, led_ctl, ka_on, kb_on, kc, kr, row, col, clrs} = 0;
    {sys_rst, term_sense, aux_n, btn_n} = 4'hF;
    lfsr = 8'h0B;
    repeat (4) @(posedge clk_sys);
    #1 check({host_txd, ka_col_n, kb_col_n, lcd_rst, lcd_bklt, buzzer, term_port_en, led_out},
             {1'b1, 4'hE, 3'h6, 5'h18});
    sys_rst = 0;
    rises = 0;
    repeat (LEN + 4 * HALF) @(posedge clk_sys);
    check(rises, LEN / (2 * HALF));
    $display("test reset done");
    for (int i = 0; i < 46; i++)
    begin
      lfsr = lfsr_next(lfsr);
      b = (i == 20) ? 8'h0A : (i == 44) ? 8'h0D : (i == 38) ? 8'h01 : 8'h20 + lfsr % 95;
      host_byte(b, i != 35);
    end
    r0 = clrs;
    host_byte(8'h0C, 1);
    check(clrs - r0, 1);
    host_byte(8'h51, 1);
    host_byte(8'h0F, 1);
    check(lcd_bklt, 0);
    host_byte(8'h0E, 1);
    check(lcd_bklt, 1);
    check(wq.size(), 0);
    r0 = rises;
    host_byte(8'h07, 1);
    repeat (LEN + 4 * HALF) @(posedge clk_sys);
    #1 check(rises - r0, LEN / (2 * HALF));
    for (int i = 0; i < 16; i++)
    begin
      lfsr = lfsr_next(lfsr);
      led_ctl = lfsr[0];
      @(posedge clk_sys);
      #1 check(led_out, led_ctl);
    end
    $display("test host bytes done");
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      kc = i[0] ? lfsr[1:0] % 3 : lfsr[1:0];
      kr = lfsr[3:2];
      ka_on = !i[0];
      kb_on = i[0];
      wait_rx(1);
      check(host.rx_q.pop_front(), {i[0] ? 4'h9 : 4'h8, kc, kr});
      {ka_on, kb_on} = 0;
      repeat (100) @(posedge clk_sys);
      #1;
    end
    $display("test keys done");
    // three sources at once, then a fourth event while the buffer is full
    {kc, kr, ka_on, aux_n, term_sense} = 7'h04;
    repeat (120) @(posedge clk_sys);
    #1 aux_n = 1;
    check(term_port_en, 1);
    wait_rx(4);
    host.rx_q.sort();
    for (int i = 0; i < 4; i++)
      check(host.rx_q.pop_front(), exp4[i]);
    {ka_on, term_sense} = 2'h1;
    wait_rx(1);
    check(host.rx_q.pop_front(), 8'hB1);
    check({term_port_en, term_sense_host}, 2'h1);
    $display("test events done");
    host_byte(8'h0F, 1);
    r0 = rises;
    btn_n = 0;
    repeat (40) @(posedge clk_sys);
    #1 check(lcd_rst, 1);
    btn_n = 1;
    repeat (40) @(posedge clk_sys);
    #1 check({lcd_rst, lcd_bklt}, 2'h1);
    repeat (LEN) @(posedge clk_sys);
    #1 check(rises - r0, LEN / (2 * HALF));
    {row, col} = 0;
    host_byte(8'h42, 1);
    check(wq.size(), 0);
    $display("test button done");
    stop_test();
  end
endmodule // test_front_panel_keypad_bell_controller

`default_nettype wire

// [pkg/fpk_map.vh]
// constants for the front panel keypad, display and bell controller
//
// Operation
// RL1: a byte of value 07 hex from the host sounds the bell.
// RL2: every reset, from the system or the panel button, also sounds the bell.
// RL3: a bell is a 2 kHz square wave on the buzzer lasting 350 ms, then silence.
// RL4: the sixteen-key 4x4 matrix is scanned and the pressed key found.
// RL5: the twelve-key 3x4 matrix is scanned as well.
// RL6: keys, display text and status travel over the asynchronous host link.
// RL7: printable bytes from the host are written to an 8 by 40 character display.
// RL8: the block itself drives the display backlight and the bell output.
// RL9: a change of the clock-hold switch line is reported to the host as a status code.
// RL10: a low on the panel reset button restarts the block and resets the display.
// RL11: while the terminal sense line is high the terminal port stays blocked and the level is passed to the host.
// RL12: the status LED follows the host control line and nothing else.
// RL13: key, switch and button inputs are debounced before they are acted on.
`ifndef FPK_MAP_VH
`define FPK_MAP_VH

// ==========================================================
// timing
`define FPK_CLK_HZ      250000000
`define FPK_BAUD        38400
`define FPK_BELL_HZ     2000
`define FPK_BELL_MS     350
`define FPK_MS_PER_S    1000
`define FPK_SCAN_HZ     1000
`define FPK_DEB_TICKS   20

// ==========================================================
// host link framing
`define FPK_DATA_BITS   8
`define FPK_FRAME_LAST  4'h9

// ==========================================================
// bytes from the host
`define FPK_CH_BELL     8'h07
`define FPK_CH_LF       8'h0A
`define FPK_CH_FF       8'h0C
`define FPK_CH_CR       8'h0D
`define FPK_CH_BL_ON    8'h0E
`define FPK_CH_BL_OFF   8'h0F
`define FPK_CH_PR_LO    8'h20
`define FPK_CH_PR_HI    8'h7E

// ==========================================================
// display geometry
`define FPK_LCD_LINES   3'h7
`define FPK_LCD_LASTCOL 6'h27

// ==========================================================
// codes to the host, upper nibble, and keypad scan limits
`define FPK_CODE_KA     4'h8
`define FPK_CODE_KB     4'h9
`define FPK_CODE_AUX    4'hA
`define FPK_CODE_SNS    4'hB
`define FPK_KEY_NONE    5'h1F
`define FPK_KB_LASTCOL  2'h2
`define FPK_LASTCOL     2'h3

`endif

// [rtl/fpk_buf2.v]
// two-entry valid/ready buffer between the event source and the transmitter
`timescale 1ns/100ps
`default_nettype none

module fpk_buf2 #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // filling side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // draining side
  output wire         out_valid,
  input  wire         out_ready,
  output reg  [W-1:0] out_data
);

  // ==========================================================
  // storage
  reg [W-1:0] spare_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // head is out_data so read data leave a flop
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r    <= 2'h0;
      out_data <= {W{1'b0}};
      spare_r  <= {W{1'b0}};
    end
    else
    begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (pop)
      begin
        if (cnt_r == 2'h2)
          out_data <= spare_r;
        else if (push)
          out_data <= in_data;
      end
      else if (push)
      begin
        if (cnt_r == 2'h0)
          out_data <= in_data;
      end
      if (push && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2)))
        spare_r <= in_data;
    end
  end

endmodule // fpk_buf2

`default_nettype wire

// [rtl/fpk_panel.v]
// front panel controller: keypad scan, display writer, bell and host link
`timescale 1ns/100ps
`default_nettype none
`include "fpk_map.vh"

module fpk_panel #(
  parameter integer BAUD_DIV  = `FPK_CLK_HZ / `FPK_BAUD,
  parameter integer SCAN_DIV  = `FPK_CLK_HZ / `FPK_SCAN_HZ,
  parameter integer BELL_HALF = `FPK_CLK_HZ / (2 * `FPK_BELL_HZ),
  parameter integer BELL_LEN  = (`FPK_CLK_HZ / `FPK_MS_PER_S) * `FPK_BELL_MS,
  parameter integer DEB_TICKS = `FPK_DEB_TICKS
) (
  // clock and reset
  input  wire       CLK_SYS,
  input  wire       SYS_RST,
  // host link
  input  wire       HOST_RXD,
  output reg        HOST_TXD,
  // keypads, rows pulled high, columns driven low one at a time
  input  wire [3:0] KA_ROW_N,
  output reg  [3:0] KA_COL_N,
  input  wire [3:0] KB_ROW_N,
  output reg  [2:0] KB_COL_N,
  // switches
  input  wire       CLK_HOLD_SW_N,
  input  wire       RST_BTN_N,
  // display
  output reg        LCD_WR,
  output reg        LCD_CLR,
  output reg        LCD_RST,
  output reg  [2:0] LCD_ROW,
  output reg  [5:0] LCD_COL,
  output reg  [7:0] LCD_DATA,
  output reg        LCD_BKLT,
  // bell
  output reg        BUZZER,
  // terminal connector and status lamp
  input  wire       TERM_SENSE,
  output reg        TERM_PORT_EN,
  output reg        TERM_SENSE_HOST,
  input  wire       LED_CTL,
  output reg        LED_OUT
);

  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA  = 2'h2;
  localparam RX_STOP  = 2'h3;

  // first low row of a column: {found, row}
  function [2:0] first_row;
    input [3:0] rows_n;
    begin
      if (!rows_n[0])      first_row = 3'h4;
      else if (!rows_n[1]) first_row = 3'h5;
      else if (!rows_n[2]) first_row = 3'h6;
      else if (!rows_n[3]) first_row = 3'h7;
      else                 first_row = 3'h0;
    end
  endfunction

  // ==========================================================
  // scan tick
  reg  [31:0] scan_cnt_r;
  wire        tick = (scan_cnt_r == SCAN_DIV - 1);

  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      scan_cnt_r <= 32'h0;
    else
      scan_cnt_r <= tick ? 32'h0 : scan_cnt_r + 32'h1;
  end

  // ==========================================================
  // switch debounce
  wire [1:0] sw_raw = {RST_BTN_N, CLK_HOLD_SW_N};
  wire [1:0] sw_deb;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_deb
      reg        st_r;
      reg [31:0] cnt_r;
      assign sw_deb[gi] = st_r;
      // RL13 settle before use
      always @(posedge CLK_SYS or posedge SYS_RST)
      begin
        if (SYS_RST)
        begin
          st_r  <= 1'b1;
          cnt_r <= 32'h0;
        end
        else if (tick)
        begin
          if (sw_raw[gi] == st_r)
            cnt_r <= 32'h0;
          else if (cnt_r == DEB_TICKS - 1)
          begin
            st_r  <= sw_raw[gi];
            cnt_r <= 32'h0;
          end
          else
            cnt_r <= cnt_r + 32'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // panel reset button
  reg  btn_prev_r;
  reg  srst_r;

  // RL10 restart on press
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      btn_prev_r <= 1'b1;
      srst_r     <= 1'b0;
      LCD_RST    <= 1'b1;
    end
    else
    begin
      btn_prev_r <= sw_deb[1];
      srst_r     <= btn_prev_r & ~sw_deb[1];
      LCD_RST    <= ~sw_deb[1];
    end
  end

  // ==========================================================
  // keypad scan
  reg  [1:0] col_r;
  reg  [4:0] found_r;
  reg  [4:0] cand_r;
  reg  [4:0] stable_r;
  reg  [31:0] kcnt_r;
  wire [2:0] ka_hit = first_row(KA_ROW_N);
  wire [2:0] kb_hit = (col_r == `FPK_LASTCOL) ? 3'h0 : first_row(KB_ROW_N);
  reg  [4:0] pass_key;
  reg        key_new;

  always @*
  begin
    pass_key = found_r;
    // RL4 sixteen-key matrix
    if (found_r == `FPK_KEY_NONE && ka_hit[2])
      pass_key = {1'b0, col_r, ka_hit[1:0]};
    // RL5 twelve-key matrix
    else if (found_r == `FPK_KEY_NONE && kb_hit[2])
      pass_key = {1'b1, col_r, kb_hit[1:0]};
  end

  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      col_r    <= 2'h0;
      KA_COL_N <= 4'hE;
      KB_COL_N <= 3'h6;
      found_r  <= `FPK_KEY_NONE;
      cand_r   <= `FPK_KEY_NONE;
      stable_r <= `FPK_KEY_NONE;
      kcnt_r   <= 32'h0;
      key_new  <= 1'b0;
    end
    else if (srst_r)
    begin
      stable_r <= `FPK_KEY_NONE;
      cand_r   <= `FPK_KEY_NONE;
      key_new  <= 1'b0;
    end
    else
    begin
      key_new <= 1'b0;
      if (tick)
      begin
        // rows are read a full tick after the column went low
        col_r    <= col_r + 2'h1;
        KA_COL_N <= ~(4'h1 << (col_r + 2'h1));
        KB_COL_N <= (col_r + 2'h1 == `FPK_LASTCOL) ? 3'h7 : ~(3'h1 << (col_r + 2'h1));
        found_r  <= (col_r == `FPK_LASTCOL) ? `FPK_KEY_NONE : pass_key;
        if (col_r == `FPK_LASTCOL)
        begin
          // RL13 same key over several passes
          if (pass_key != cand_r)
          begin
            cand_r <= pass_key;
            kcnt_r <= 32'h0;
          end
          else if (kcnt_r == DEB_TICKS - 1)
          begin
            kcnt_r   <= 32'h0;
            stable_r <= cand_r;
            key_new  <= (cand_r != stable_r) && (cand_r != `FPK_KEY_NONE);
          end
          else if (cand_r != stable_r)
            kcnt_r <= kcnt_r + 32'h1;
        end
      end
    end
  end

  // ==========================================================
  // events toward the host
  reg        key_pend_r;
  reg        aux_pend_r;
  reg        sns_pend_r;
  reg        aux_prev_r;
  reg        sns_prev_r;
  reg  [3:0] key_idx_r;
  reg        key_mat_r;
  wire       ev_ready;
  wire       ev_valid = key_pend_r | aux_pend_r | sns_pend_r;
  wire       take = ev_valid & ev_ready;
  wire       aux_set = (aux_prev_r != sw_deb[0]);
  wire       sns_set = (sns_prev_r != TERM_SENSE_HOST);
  reg  [7:0] ev_data;

  always @*
  begin
    if (key_pend_r)
      ev_data = {key_mat_r ? `FPK_CODE_KB : `FPK_CODE_KA, key_idx_r};
    else if (aux_pend_r)
      ev_data = {`FPK_CODE_AUX, 3'h0, aux_prev_r};
    else
      ev_data = {`FPK_CODE_SNS, 3'h0, sns_prev_r};
  end

  // an event in the cycle of its take stays pending
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      key_pend_r <= 1'b0;
      aux_pend_r <= 1'b0;
      sns_pend_r <= 1'b0;
      aux_prev_r <= 1'b1;
      sns_prev_r <= 1'b1;
      key_idx_r  <= 4'h0;
      key_mat_r  <= 1'b0;
      TERM_PORT_EN    <= 1'b0;
      TERM_SENSE_HOST <= 1'b1;
      LED_OUT    <= 1'b0;
    end
    else
    begin
      // RL11 sense high blocks the terminal port
      TERM_PORT_EN    <= ~TERM_SENSE;
      TERM_SENSE_HOST <= TERM_SENSE;
      // RL12 lamp follows host line
      LED_OUT    <= LED_CTL;
      aux_prev_r <= sw_deb[0];
      sns_prev_r <= TERM_SENSE_HOST;
      if (key_new)
      begin
        key_mat_r <= stable_r[4];
        key_idx_r <= stable_r[4] ? {2'h0, stable_r[3:2]} * 4'h4 + {2'h0, stable_r[1:0]}
                                 : stable_r[3:0];
      end
      key_pend_r <= key_new | (key_pend_r & ~(take & key_pend_r));
      // RL9 switch position report
      aux_pend_r <= aux_set | (aux_pend_r & ~(take & ~key_pend_r));
      // RL11 sense level report
      sns_pend_r <= sns_set | (sns_pend_r & ~(take & ~key_pend_r & ~aux_pend_r));
    end
  end

  // ==========================================================
  // transmit buffer and serialiser
  wire       tx_valid;
  wire [7:0] tx_data;
  reg        tx_busy_r;
  reg  [9:0] tx_sh_r;
  reg  [3:0] tx_bit_r;
  reg [31:0] tx_cnt_r;

  fpk_buf2 #(.W(8)) u_buf (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (ev_valid),
    .in_ready  (ev_ready),
    .in_data   (ev_data),
    .out_valid (tx_valid),
    .out_ready (~tx_busy_r),
    .out_data  (tx_data)
  );

  // RL6 8N1 frames to the host
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 10'h3FF;
      tx_bit_r  <= 4'h0;
      tx_cnt_r  <= 32'h0;
      HOST_TXD  <= 1'b1;
    end
    else if (!tx_busy_r)
    begin
      HOST_TXD <= 1'b1;
      if (tx_valid)
      begin
        tx_busy_r <= 1'b1;
        tx_sh_r   <= {1'b1, tx_data, 1'b0};
        tx_bit_r  <= 4'h0;
        tx_cnt_r  <= 32'h0;
      end
    end
    else
    begin
      HOST_TXD <= tx_sh_r[0];
      if (tx_cnt_r == BAUD_DIV - 1)
      begin
        tx_cnt_r <= 32'h0;
        tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
        tx_bit_r <= tx_bit_r + 4'h1;
        tx_busy_r <= (tx_bit_r != `FPK_FRAME_LAST);
      end
      else
        tx_cnt_r <= tx_cnt_r + 32'h1;
    end
  end

  // ==========================================================
  // receiver
  reg  [1:0]  rx_st_r;
  reg  [31:0] rx_cnt_r;
  reg  [3:0]  rx_bit_r;
  reg  [7:0]  rx_sh_r;
  reg         rx_vld_r;

  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= 32'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r  <= 8'h00;
      rx_vld_r <= 1'b0;
    end
    else
    begin
      rx_vld_r <= 1'b0;
      rx_cnt_r <= rx_cnt_r + 32'h1;
      case (rx_st_r)
        RX_IDLE:
        begin
          rx_cnt_r <= 32'h0;
          if (!HOST_RXD)
            rx_st_r <= RX_START;
        end
        RX_START:
          if (rx_cnt_r == BAUD_DIV / 2 - 1)
          begin
            rx_cnt_r <= 32'h0;
            rx_bit_r <= 4'h0;
            rx_st_r  <= HOST_RXD ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_cnt_r == BAUD_DIV - 1)
          begin
            rx_cnt_r <= 32'h0;
            rx_sh_r  <= {HOST_RXD, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == `FPK_DATA_BITS - 1)
              rx_st_r <= RX_STOP;
          end
        RX_STOP:
          if (rx_cnt_r == BAUD_DIV - 1)
          begin
            rx_st_r  <= RX_IDLE;
            // a broken stop bit drops the byte
            rx_vld_r <= HOST_RXD;
          end
        default:
          rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // display writer
  wire printable = (rx_sh_r >= `FPK_CH_PR_LO) && (rx_sh_r <= `FPK_CH_PR_HI);

  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      LCD_WR   <= 1'b0;
      LCD_CLR  <= 1'b0;
      LCD_ROW  <= 3'h0;
      LCD_COL  <= 6'h00;
      LCD_DATA <= 8'h00;
      LCD_BKLT <= 1'b1;
    end
    else if (srst_r)
    begin
      LCD_WR   <= 1'b0;
      LCD_CLR  <= 1'b0;
      LCD_ROW  <= 3'h0;
      LCD_COL  <= 6'h00;
      LCD_BKLT <= 1'b1;
    end
    else
    begin
      // previous write's place is held one cycle with its strobe
      if (LCD_WR)
      begin
        LCD_COL <= (LCD_COL == `FPK_LCD_LASTCOL) ? 6'h00 : LCD_COL + 6'h01;
        if (LCD_COL == `FPK_LCD_LASTCOL)
          LCD_ROW <= LCD_ROW + 3'h1;
      end
      LCD_WR  <= 1'b0;
      LCD_CLR <= 1'b0;
      if (rx_vld_r)
      begin
        // RL7 text into the 8x40 display
        if (printable)
        begin
          LCD_WR   <= 1'b1;
          LCD_DATA <= rx_sh_r;
        end
        else if (rx_sh_r == `FPK_CH_CR)
          LCD_COL <= 6'h00;
        else if (rx_sh_r == `FPK_CH_LF)
          LCD_ROW <= (LCD_ROW == `FPK_LCD_LINES) ? 3'h0 : LCD_ROW + 3'h1;
        else if (rx_sh_r == `FPK_CH_FF)
        begin
          LCD_CLR <= 1'b1;
          LCD_ROW <= 3'h0;
          LCD_COL <= 6'h00;
        end
        // RL8 backlight switched here
        else if (rx_sh_r == `FPK_CH_BL_ON)
          LCD_BKLT <= 1'b1;
        else if (rx_sh_r == `FPK_CH_BL_OFF)
          LCD_BKLT <= 1'b0;
      end
    end
  end

  // ==========================================================
  // bell
  reg  [31:0] bell_len_r;
  reg  [31:0] bell_half_r;
  reg         bell_on_r;
  // RL1 bell byte
  wire        bell_hit = rx_vld_r && (rx_sh_r == `FPK_CH_BELL);

  // starts sounding straight out of system reset
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      bell_on_r   <= 1'b1;
      bell_len_r  <= 32'h0;
      bell_half_r <= 32'h0;
      BUZZER      <= 1'b0;
    end
    // RL2 panel reset rings too
    else if (bell_hit || srst_r)
    begin
      bell_on_r   <= 1'b1;
      bell_len_r  <= 32'h0;
      bell_half_r <= 32'h0;
      BUZZER      <= 1'b0;
    end
    else if (bell_on_r)
    begin
      // RL3 square wave for a fixed time
      bell_len_r  <= bell_len_r + 32'h1;
      bell_half_r <= (bell_half_r == BELL_HALF - 1) ? 32'h0 : bell_half_r + 32'h1;
      if (bell_half_r == BELL_HALF - 1)
        BUZZER <= ~BUZZER;
      if (bell_len_r == BELL_LEN - 1)
      begin
        bell_on_r <= 1'b0;
        BUZZER    <= 1'b0;
      end
    end
  end

endmodule // fpk_panel

`default_nettype wire
